// ===== lbr_pkg.sv
// constants and carrier types shared by the lane block reorder design
package lbr_pkg;
	// element width and lane/address geometry; sizes are exponents so they stay powers of two
	localparam int LANE_BITS  = 2;
	localparam int ADDR_BITS  = 8;
	localparam int SLOT_BITS  = ADDR_BITS - LANE_BITS;
	localparam int LANE_CNT   = 1 << LANE_BITS;
	localparam int BLOCK_LEN  = 1 << ADDR_BITS;
	localparam int IDX_W      = $clog2(ADDR_BITS);
	localparam int DATA_W     = 16;
	localparam int FIFO_DEPTH = 8;
	localparam int BANK_CNT   = 2;

	localparam logic [SLOT_BITS-1:0] SLOT_FIRST = 6'h00;
	localparam logic [SLOT_BITS-1:0] SLOT_LAST  = 6'h3F;
	localparam logic [SLOT_BITS-1:0] SLOT_STEP  = 6'h01;

	typedef logic [DATA_W-1:0] lbr_elem_t;

	// one lane-vector: lane 0 carries address bits [LANE_BITS-1:0] = 0
	typedef struct packed {
		lbr_elem_t [LANE_CNT-1:0] lane;
	} lbr_vec_t;

	// entry i names the source address bit that becomes output bit i
	typedef logic [ADDR_BITS-1:0][IDX_W-1:0] lbr_perm_t;

	localparam lbr_perm_t PERM_IDENT = {3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
endpackage

// ===== lane_block_reorder.sv
// input fifo and double-banked permuting reorder buffer for lane-parallel blocks
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module lbr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// fill side
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	// drain side
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam int CNT_W = PTR_W + 1;
	localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
	localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);
	localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
	localparam logic [PTR_W-1:0] PTR_ONE  = PTR_W'(1);

	logic [WIDTH-1:0] store [DEPTH];
	logic [PTR_W-1:0] wrPtr_r;
	logic [PTR_W-1:0] wrPtr_nxt;
	logic [PTR_W-1:0] rdPtr_r;
	logic [PTR_W-1:0] rdPtr_nxt;
	logic [CNT_W-1:0] count_r;
	logic [CNT_W-1:0] count_nxt;
	logic             ready_r;
	logic             empty_r;
	logic             push;
	logic             pop;

	assign push     = inValid && ready_r;
	assign pop      = outReady && !empty_r;
	// ready is a flop of the next fill level, so it is already low on the edge the fifo is full
	assign inReady  = ready_r;
	assign outValid = !empty_r;
	assign outData  = store[rdPtr_r];

	always_comb begin
		wrPtr_nxt = wrPtr_r;
		rdPtr_nxt = rdPtr_r;
		count_nxt = count_r;
		if (push) begin
			wrPtr_nxt = (wrPtr_r == PTR_LAST) ? '0 : wrPtr_r + PTR_ONE;
		end
		if (pop) begin
			rdPtr_nxt = (rdPtr_r == PTR_LAST) ? '0 : rdPtr_r + PTR_ONE;
		end
		if (push && !pop) begin
			count_nxt = count_r + CNT_ONE;
		end else if (pop && !push) begin
			count_nxt = count_r - CNT_ONE;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
			ready_r <= 1'b0;
			empty_r <= 1'b1;
		end else begin
			wrPtr_r <= wrPtr_nxt;
			rdPtr_r <= rdPtr_nxt;
			count_r <= count_nxt;
			ready_r <= (count_nxt != CNT_FULL);
			empty_r <= (count_nxt == '0);
		end
	end

	// storage holds data only, so it carries no reset
	always_ff @(posedge clk) begin
		if (push) begin
			store[wrPtr_r] <= inData;
		end
	end
endmodule // lbr_fifo

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - block length and lane count are powers of two
// - reordered block leaves on all parallel lanes
// - address is slot bits above lane bits
// - address bit zero is the least significant
// - permutation entry i selects output bit i
// - reversed list gives full bit reversal
// - paired reversed list gives radix-4 digit reversal
// - identity list keeps original lane and slot
// - rotation list moves top bits to bottom
// - inverse rotation moves bottom bits to top
// - lane exponent sets two-power lane count
module lane_block_reorder (
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             sys_rst,
	// upstream stream
	input  wire logic             inStrobe,
	input  wire lbr_pkg::lbr_vec_t inData,
	output logic                  inReady,
	// permutation, taken when a block's first vector is stored
	input  wire lbr_pkg::lbr_perm_t permVec,
	// downstream stream
	output logic                  result_strobe,
	output lbr_pkg::lbr_vec_t     outData
);
	// new address bit i takes source bit p[i]
	function automatic logic [lbr_pkg::ADDR_BITS-1:0] permuteAddr(
		input logic [lbr_pkg::ADDR_BITS-1:0] src,
		input lbr_pkg::lbr_perm_t             p
	);
		logic [lbr_pkg::ADDR_BITS-1:0] dst;
		dst = '0;
		for (int i = 0; i < lbr_pkg::ADDR_BITS; i++) begin
			dst[i] = src[p[i]];
		end
		return dst;
	endfunction

	typedef enum logic [1:0] {
		RD_IDLE = 2'b01,
		RD_SEND = 2'b10
	} lbr_rd_state_t;

	lbr_pkg::lbr_elem_t mem [lbr_pkg::BANK_CNT * lbr_pkg::BLOCK_LEN];

	logic                  fifoValid;
	logic                  fifoReady;
	lbr_pkg::lbr_vec_t     fifoData;

	logic                  wrBank_r;
	logic                  wrBank_nxt;
	logic [lbr_pkg::SLOT_BITS-1:0] wrSlot_r;
	logic [lbr_pkg::SLOT_BITS-1:0] wrSlot_nxt;
	lbr_pkg::lbr_perm_t    curPerm_r;
	lbr_pkg::lbr_perm_t    curPerm_nxt;
	lbr_pkg::lbr_perm_t    usePerm;
	logic [lbr_pkg::BANK_CNT-1:0] bankFull_r;
	logic [lbr_pkg::BANK_CNT-1:0] bankFull_nxt;
	logic                  rdBank_r;
	logic                  rdBank_nxt;
	logic [lbr_pkg::SLOT_BITS-1:0] rdSlot_r;
	logic [lbr_pkg::SLOT_BITS-1:0] rdSlot_nxt;
	lbr_rd_state_t         rdState_r;
	lbr_rd_state_t         rdState_nxt;
	logic                  strobe_nxt;
	lbr_pkg::lbr_vec_t     outData_nxt;
	logic                  pop;
	logic [lbr_pkg::ADDR_BITS-1:0] dstAddr [lbr_pkg::LANE_CNT];

	////////////////////////////////////////////////////////////////////////////
	// input fifo; upstream must hold off while inReady is low
	lbr_fifo #(
		.WIDTH ($bits(lbr_pkg::lbr_vec_t)),
		.DEPTH (lbr_pkg::FIFO_DEPTH)
	) inFifo (
		.clk      (core_clk),
		.rst      (sys_rst),
		.inValid  (inStrobe),
		.inReady  (fifoReady),
		.inData   (inData),
		.outValid (fifoValid),
		.outReady (pop),
		.outData  (fifoData)
	);
	// upstream sees the fifo's own ready flop, with no extra cycle of lag behind it
	assign inReady = fifoReady;

	// fifo drains only into a free bank, so a busy reader backs up to upstream
	assign pop     = fifoValid && !bankFull_r[wrBank_r];
	assign usePerm = (wrSlot_r == lbr_pkg::SLOT_FIRST) ? permVec : curPerm_r;

	////////////////////////////////////////////////////////////////////////////
	// write side: scatter each lane to its permuted address
	for (genvar l = 0; l < lbr_pkg::LANE_CNT; l++) begin : gLaneWr
		localparam logic [lbr_pkg::LANE_BITS-1:0] LIDX = (lbr_pkg::LANE_BITS)'(l);
		assign dstAddr[l] = permuteAddr({wrSlot_r, LIDX}, usePerm);
	end

	// one writer process owns the buffer; a legal permutation never lands two lanes together
	always_ff @(posedge core_clk) begin
		if (pop) begin
			for (int l = 0; l < lbr_pkg::LANE_CNT; l++) begin
				mem[{wrBank_r, dstAddr[l]}] <= fifoData.lane[l];
			end
		end
	end

	always_comb begin
		wrBank_nxt  = wrBank_r;
		wrSlot_nxt  = wrSlot_r;
		curPerm_nxt = curPerm_r;
		if (pop) begin
			curPerm_nxt = usePerm;
			wrSlot_nxt  = wrSlot_r + lbr_pkg::SLOT_STEP;
			if (wrSlot_r == lbr_pkg::SLOT_LAST) begin
				wrBank_nxt = !wrBank_r;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read side: stream a completed bank out in natural address order
	always_comb begin
		rdState_nxt  = rdState_r;
		rdBank_nxt   = rdBank_r;
		rdSlot_nxt   = rdSlot_r;
		strobe_nxt   = 1'b0;
		outData_nxt  = outData;
		bankFull_nxt = bankFull_r;
		case (rdState_r)
			RD_IDLE: begin
				if (bankFull_r[rdBank_r]) begin
					rdState_nxt = RD_SEND;
				end
			end
			RD_SEND: begin
				strobe_nxt = 1'b1;
				for (int l = 0; l < lbr_pkg::LANE_CNT; l++) begin
					outData_nxt.lane[l] = mem[{rdBank_r, rdSlot_r, l[lbr_pkg::LANE_BITS-1:0]}];
				end
				rdSlot_nxt = rdSlot_r + lbr_pkg::SLOT_STEP;
				if (rdSlot_r == lbr_pkg::SLOT_LAST) begin
					bankFull_nxt[rdBank_r] = 1'b0;
					rdBank_nxt             = !rdBank_r;
					rdState_nxt            = RD_IDLE;
				end
			end
			default: begin
				rdState_nxt = RD_IDLE;
			end
		endcase
		// a bank filling in this cycle is marked after any release, so set wins
		if (pop && (wrSlot_r == lbr_pkg::SLOT_LAST)) begin
			bankFull_nxt[wrBank_r] = 1'b1;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wrBank_r      <= 1'b0;
			wrSlot_r      <= lbr_pkg::SLOT_FIRST;
			curPerm_r     <= lbr_pkg::PERM_IDENT;
			bankFull_r    <= '0;
			rdBank_r      <= 1'b0;
			rdSlot_r      <= lbr_pkg::SLOT_FIRST;
			rdState_r     <= RD_IDLE;
			result_strobe <= 1'b0;
			outData       <= '0;
		end else begin
			wrBank_r      <= wrBank_nxt;
			wrSlot_r      <= wrSlot_nxt;
			curPerm_r     <= curPerm_nxt;
			bankFull_r    <= bankFull_nxt;
			rdBank_r      <= rdBank_nxt;
			rdSlot_r      <= rdSlot_nxt;
			rdState_r     <= rdState_nxt;
			result_strobe <= strobe_nxt;
			outData       <= outData_nxt;
		end
	end
endmodule // lane_block_reorder

`default_nettype wire

// ===== lbr_chk_assertions.sv
// port assertions for the lane block reorder
`timescale 1ns/10ps
`default_nettype none
module lbr_chk (
	// clock and reset
	input wire logic              core_clk,
	input wire logic              sys_rst,
	// streams
	input wire logic              inStrobe,
	input wire logic              inReady,
	input wire logic              result_strobe,
	input wire lbr_pkg::lbr_vec_t outData
);
	logic [15:0] inCnt_r;
	logic [15:0] outCnt_r;
	logic [6:0]  runCnt_r;
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			inCnt_r <= 16'h0000;
			outCnt_r <= 16'h0000;
			runCnt_r <= 7'h00;
		end else begin
			inCnt_r <= inCnt_r + 16'(inStrobe && inReady);
			outCnt_r <= outCnt_r + 16'(result_strobe);
			runCnt_r <= result_strobe ? runCnt_r + 7'h01 : 7'h00;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	AST_RST_QUIET: assert property ($fell(sys_rst) |-> !result_strobe && outData == '0)
		else $error("output active at reset release");
	AST_RDY_UP: assert property ($fell(sys_rst) |-> !inReady ##1 inReady)
		else $error("ready not raised after reset");
	AST_RUN_LEN: assert property ($fell(result_strobe) |-> runCnt_r == 7'h40)
		else $error("output run not one block");
	AST_RUN_MAX: assert property (result_strobe |-> runCnt_r < 7'h40)
		else $error("output run too long");
	AST_BLK_START: assert property ($rose(result_strobe) |-> outCnt_r[5:0] == 6'h00)
		else $error("output block not whole");
	AST_LATENCY: assert property (result_strobe |-> inCnt_r >= {outCnt_r[15:6] + 10'h001, 6'h00})
		else $error("output before block stored");
	AST_GAP: assert property (result_strobe && runCnt_r == 7'h3F |=> !result_strobe)
		else $error("no idle cycle after a block");
	AST_HOLD: assert property (!result_strobe |-> $stable(outData))
		else $error("data moved without strobe");
endmodule // lbr_chk
bind lane_block_reorder lbr_chk u_chk (.core_clk, .sys_rst, .inStrobe, .inReady,
	.result_strobe, .outData);
`default_nettype wire

// ===== lbr_src.sv
// upstream source model feeding whole blocks under the ready handshake
`timescale 1ns/10ps
`default_nettype none
module lbr_src (
	// clock and handshake
	input wire logic          clk,
	input wire logic          inReady,
	// stream
	output logic              inStrobe,
	output lbr_pkg::lbr_vec_t inData
);
	initial begin
		inStrobe = 1'b0;
		inData = '0;
	end
	// element value is {block, address} so every output traces back to its source
	task automatic send(input int n);
		int k;
		k = 0;
		while (k < n * 64) begin
			@(negedge clk);
			inStrobe = inReady;
			if (inReady) begin
				for (int l = 0; l < 4; l++) inData.lane[l] = {k[13:6], k[5:0], 2'(l)};
				k++;
			end else inData = ~inData;
		end
		@(negedge clk);
		inStrobe = 1'b0;
		inData = ~inData;
	endtask
endmodule // lbr_src
`default_nettype wire

// ===== lane_block_reorder_tb.sv
// self-checking bench for the lane block reorder
`timescale 1ns/10ps
`default_nettype none
module lane_block_reorder_tb;
	logic               core_clk;
	logic               sys_rst;
	logic               inStrobe;
	logic               inReady;
	logic               result_strobe;
	logic               sawFull;
	lbr_pkg::lbr_vec_t  inData;
	lbr_pkg::lbr_vec_t  outData;
	lbr_pkg::lbr_perm_t permVec;
	int                 bad_count;
	int                 check_count;
	lane_block_reorder DUT (.core_clk, .sys_rst, .inStrobe, .inData, .inReady, .permVec,
		.result_strobe, .outData);
	lbr_src u_src (.clk(core_clk), .inReady, .inStrobe, .inData);
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// ready only drops when the fifo refuses
	always @(negedge core_clk) if (!sys_rst && inReady === 1'b0) sawFull = 1'b1;
	////////////////////////////////////////////////////////////////////////////
	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk_elem(input lbr_pkg::lbr_elem_t got, input lbr_pkg::lbr_elem_t exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_elem({15'h0000, got}, {15'h0000, exp});
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic run(input int n, input lbr_pkg::lbr_perm_t p);
		int v;
		int t;
		logic [7:0] a;
		logic [7:0] b;
		v = 0;
		t = 0;
		@(negedge core_clk);
		permVec = p;
		// ready is low only at reset release before this point, so start the watch here
		sawFull = 1'b0;
		fork
			u_src.send(n);
			while (v < n * 64) begin
				@(negedge core_clk);
				t++;
				if (t > n * 300 + 400) begin
					bad_count++;
					final_report();
				end
				if (result_strobe === 1'b1) begin
					for (int l = 0; l < 4; l++) begin
						b = {v[5:0], 2'(l)};
						for (int i = 0; i < 8; i++) a[p[i]] = b[i];
						chk_elem(outData.lane[l], {v[13:6], a});
					end
					v++;
				end
			end
		join
	endtask
	task automatic sc_reset;
		@(negedge core_clk);
		sys_rst = 1'b1;
		repeat (2) @(negedge core_clk);
		chk_bit(result_strobe, 1'b0);
		chk_bit(inReady, 1'b0);
		chk_elem(outData.lane[0], 16'h0000);
		sys_rst = 1'b0;
	endtask
	initial begin
		sys_rst = 1'b1;
		permVec = lbr_pkg::PERM_IDENT;
		bad_count = 0;
		check_count = 0;
		sawFull = 1'b0;
		repeat (10) @(negedge core_clk);
		sys_rst = 1'b0;
		// the reader idles one cycle per block, so ten back-to-back blocks fill the fifo
		run(10, 24'h053977);
		chk_bit(sawFull, 1'b1);
		run(1, 24'h21AB3E);
		sc_reset();
		run(1, lbr_pkg::PERM_IDENT);
		run(1, 24'hB1A23E);
		run(1, 24'h23EB1A);
		final_report();
	end
endmodule // lane_block_reorder_tb
`default_nettype wire
